// ### psi_core.sv
// Program counter, return stack and indirect data port with APB slave
`timescale 1ns/100ps
module psi_core
#(
   parameter int BANKS = psi_pkg::PSI_BANKS_DEF
)
(
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire psi_pkg::psi_op_t op,
   input  wire logic [8:0]       op_addr,
   input  wire logic [7:0]       op_lit,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [7:0]       ram_rdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic [31:0]           prdata,
   output logic [11:0]           fetch_addr,
   output logic [7:0]            wreg_out,
   output logic [6:0]            ram_addr,
   output logic                  ram_we,
   output logic                  ram_re,
   output logic [7:0]            ram_wdata
);
   import psi_pkg::*;

   psi_state_t st_r;
   psi_state_t st_nxt;

   // Unimplemented upper pointer bits read as ones per variant
   localparam logic [7:0] PTR_ONES = (BANKS == 1) ? 8'he0 :
                                     (BANKS == 2) ? 8'hc0 : 8'h80;

   logic [7:0]  ptr_view;
   logic [11:0] pc_inc;
   logic        acc;
   logic        setup;
   logic [7:0]  ind_rd;

   assign ptr_view = st_r.ptr | PTR_ONES;
   assign pc_inc   = st_r.pc + 12'h001;
   assign setup    = psel & ~penable;
   assign acc      = psel & penable & st_r.pready;
   assign ind_rd   = (st_r.ptr[4:0] == PSI_DPORT_IDX[4:0]) ? 8'h00 : ram_rdata;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.ram_we = 1'b0;
      st_nxt.ram_re = 1'b0;
      // Instruction sequencing; no overflow flags by design
      case (op)
         PSI_OP_JUMP:
         begin
            st_nxt.pc = {2'b00, st_r.status[PSI_PAGE_BIT], op_addr};
         end
         PSI_OP_CALL:
         begin
            st_nxt.stk2 = st_r.stk1;
            st_nxt.stk1 = pc_inc;
            st_nxt.pc   = {2'b00, st_r.status[PSI_PAGE_BIT], 1'b0, op_addr[7:0]};
         end
         PSI_OP_RET:
         begin
            st_nxt.pc   = st_r.stk1;
            st_nxt.stk1 = st_r.stk2;
            st_nxt.wreg = op_lit;
         end
         PSI_OP_PCLWR:
         begin
            st_nxt.pc = {2'b00, st_r.status[PSI_PAGE_BIT], 1'b0, op_lit};
         end
         default:
         begin
            st_nxt.pc = pc_inc;
         end
      endcase
      // Two cycles to answer: the RAM read strobed at setup is captured
      // into prdata together with pready, so read data stands with pready
      st_nxt.pready = 1'b0;
      if (setup)
      begin
         st_nxt.ram_addr = {ptr_view[6:5] & 2'(BANKS - 1), st_r.ptr[4:0]};
         st_nxt.ram_re   = (paddr == PSI_ADDR_DPORT) & ~pwrite;
      end
      if (psel & penable & ~st_r.pready)
      begin
         st_nxt.pready = 1'b1;
         if (!pwrite)
         begin
            if (paddr == PSI_ADDR_PTR)
               st_nxt.prdata = {24'h000000, ptr_view};
            else if (paddr == PSI_ADDR_PCL)
               st_nxt.prdata = {24'h000000, st_r.pc[7:0]};
            else if (paddr == PSI_ADDR_DPORT)
               st_nxt.prdata = {24'h000000, ind_rd};
            else if (paddr == PSI_ADDR_STATUS)
               st_nxt.prdata = {24'h000000, st_r.status};
            else if (paddr == PSI_ADDR_PC)
               st_nxt.prdata = {20'h00000, st_r.pc};
            else if (paddr == PSI_ADDR_WREG)
               st_nxt.prdata = {24'h000000, st_r.wreg};
            else
               st_nxt.prdata = 32'h00000000;
         end
      end
      if (acc)
      begin
         st_nxt.pready = 1'b0;
         if (pwrite)
         begin
            if (paddr == PSI_ADDR_PTR)
               st_nxt.ptr = pwdata[7:0];
            else if (paddr == PSI_ADDR_PCL)
               st_nxt.pc = {2'b00, st_r.status[PSI_PAGE_BIT], 1'b0, pwdata[7:0]};
            else if (paddr == PSI_ADDR_DPORT)
            begin
               st_nxt.ram_we    = st_r.ptr[4:0] != PSI_DPORT_IDX[4:0];
               st_nxt.ram_wdata = pwdata[7:0];
            end
            else if (paddr == PSI_ADDR_STATUS)
               st_nxt.status[PSI_PAGE_BIT] = pwdata[PSI_PAGE_BIT];
         end
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r        <= '0;
         st_r.pc     <= PSI_PC_RST;
         st_r.status <= PSI_STATUS_RST;
         st_r.ptr    <= PSI_PTR_RST;
      end
      else
         st_r <= st_nxt;
   end

   assign pready     = st_r.pready;
   assign pslverr    = 1'b0;
   assign prdata     = st_r.prdata;
   assign fetch_addr = st_r.pc;
   assign wreg_out   = st_r.wreg;
   assign ram_addr   = st_r.ram_addr;
   assign ram_we     = st_r.ram_we;
   assign ram_re     = st_r.ram_re;
   assign ram_wdata  = st_r.ram_wdata;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   pc_step_a: assert property (op == PSI_OP_NONE && !(acc && pwrite && paddr == PSI_ADDR_PCL)
      |=> fetch_addr == $past(fetch_addr) + 12'h001) else $error("pc did not step");
   jump_load_a: assert property (op == PSI_OP_JUMP && !acc
      |=> fetch_addr[8:0] == $past(op_addr)) else $error("jump field not loaded");
   page_bit_a: assert property (op == PSI_OP_JUMP && !acc
      |=> fetch_addr[9] == $past(st_r.status[5])) else $error("page bit lost");
   call_bit8_a: assert property (op == PSI_OP_CALL && !acc
      |=> fetch_addr[8] == 1'b0) else $error("call left bit 8 set");
   call_push_a: assert property (op == PSI_OP_CALL
      |=> st_r.stk1 == $past(fetch_addr) + 12'h001 && st_r.stk2 == $past(st_r.stk1))
      else $error("call push wrong");
   ret_pop_a: assert property (op == PSI_OP_RET && !acc
      |=> fetch_addr == $past(st_r.stk1) && st_r.stk1 == $past(st_r.stk2)
          && wreg_out == $past(op_lit)) else $error("return pop wrong");
   ind_zero_a: assert property (psel && penable && !pready && !pwrite
      && paddr == PSI_ADDR_DPORT && st_r.ptr[4:0] == 5'h00
      |=> prdata == 32'h00000000) else $error("pointer zero read not 00h");
   ind_nowr_a: assert property (acc && pwrite && st_r.ptr[4:0] == 5'h00
      |=> !ram_we) else $error("write to data port itself stored");
   apb_wait_a: assert property (setup |=> !pready ##1 pready) else $error("apb timing");
   apb_done_a: assert property (acc |=> !pready) else $error("pready held too long");
   pcl_write_a: assert property (acc && pwrite && paddr == PSI_ADDR_PCL
      |=> fetch_addr == {2'b00, $past(st_r.status[PSI_PAGE_BIT]), 1'b0, $past(pwdata[7:0])})
      else $error("low counter write not applied");
   pcl_op_a: assert property (op == PSI_OP_PCLWR && !acc
      |=> fetch_addr[8] == 1'b0 && fetch_addr[7:0] == $past(op_lit))
      else $error("computed jump wrong");
   call_page_a: assert property (op == PSI_OP_CALL && !acc
      |=> fetch_addr[9] == $past(st_r.status[PSI_PAGE_BIT]))
      else $error("call page bit lost");
   ret_deep_a: assert property (op == PSI_OP_RET
      |=> st_r.stk2 == $past(st_r.stk2)) else $error("level 2 changed on return");
   wrap_zero_a: assert property (fetch_addr == 12'hfff && op == PSI_OP_NONE && !acc
      |=> fetch_addr == 12'h000) else $error("no wrap after reset vector");
   ptr_top_a: assert property (psel && penable && !pready && !pwrite && paddr == PSI_ADDR_PTR
      |=> prdata[7] == 1'b1) else $error("pointer top bit not one");
   dport_wr_a: assert property (acc && pwrite && paddr == PSI_ADDR_DPORT
      && st_r.ptr[4:0] != 5'h00
      |=> ram_we && ram_wdata == $past(pwdata[7:0])) else $error("indirect write lost");
   low_addr_a: assert property (setup && paddr == PSI_ADDR_DPORT
      |=> ram_addr[4:0] == $past(st_r.ptr[4:0])) else $error("pointer low bits lost");

   call_c: cover property (op == PSI_OP_CALL ##1 op == PSI_OP_CALL ##1 op == PSI_OP_CALL);
   pcl_c: cover property (acc && pwrite && paddr == PSI_ADDR_PCL);
   ret_c: cover property (op == PSI_OP_RET ##1 op == PSI_OP_RET ##1 op == PSI_OP_RET);
   ind_c: cover property (acc && paddr == PSI_ADDR_DPORT);

endmodule : psi_core

// ### psi_core_test.sv
// Self-checking bench for program flow, return stack and data port
`timescale 1ns/100ps
module psi_core_test;
   import psi_pkg::*;
   typedef struct packed
   {
      psi_op_t o; logic [8:0] a; logic [7:0] l; logic [11:0] pc; logic [7:0] w;
   } psi_row_t;
   psi_op_t     op = PSI_OP_NONE;
   logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [8:0]  op_addr = 9'h000;
   logic [7:0]  op_lit = 8'h00, paddr = 8'h00, ram_rdata, wreg_out, ram_wdata;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [11:0] fetch_addr, pc_seen;
   logic [6:0]  ram_addr;
   logic        pready, pslverr, ram_we, ram_re;
   int          n_fail = 0, comparisons = 0, n_we = 0, c;
   psi_row_t    rows [11] = '{
      '{PSI_OP_NONE, 9'h000, 8'h00, 12'h000, 8'h00},
      '{PSI_OP_NONE, 9'h000, 8'h00, 12'h001, 8'h00},
      '{PSI_OP_JUMP, 9'h1a5, 8'h00, 12'h1a5, 8'h00},
      '{PSI_OP_CALL, 9'h1f3, 8'h00, 12'h0f3, 8'h00},
      '{PSI_OP_CALL, 9'h044, 8'h00, 12'h044, 8'h00},
      '{PSI_OP_CALL, 9'h080, 8'h00, 12'h080, 8'h00},
      '{PSI_OP_RET,  9'h000, 8'h5a, 12'h045, 8'h5a},
      '{PSI_OP_RET,  9'h000, 8'hc3, 12'h0f4, 8'hc3},
      '{PSI_OP_RET,  9'h000, 8'h3c, 12'h0f4, 8'h3c},
      '{PSI_OP_JUMP, 9'h1ff, 8'h00, 12'h1ff, 8'h3c},
      '{PSI_OP_PCLWR, 9'h000, 8'h9e, 12'h09e, 8'h3c}
   };
   always #25 clock = ~clock;
   always @(posedge clock)
      if (ram_we === 1'b1)
         n_we++;
   psi_core u_psi_core (.clock(clock), .sys_rst(sys_rst), .op(op), .op_addr(op_addr),
      .op_lit(op_lit), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .ram_rdata(ram_rdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .fetch_addr(fetch_addr), .wreg_out(wreg_out), .ram_addr(ram_addr),
      .ram_we(ram_we), .ram_re(ram_re), .ram_wdata(ram_wdata));
   psi_ram_model u_psi_ram_model (.clock(clock), .ram_addr(ram_addr), .ram_we(ram_we),
      .ram_re(ram_re), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wrap_up;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (8) @(posedge clock);
      chk("reset vector", 32'hfff, 32'(fetch_addr));
      sys_rst <= 1'b0;
   endtask : do_reset
   // APB master: entered and left just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      chk("pready", 32'h1, 32'(pready));
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clock);
      pc_seen = fetch_addr;
      @(posedge clock);
   endtask : apb
   task automatic one(input psi_op_t o, input logic [8:0] a, input logic [11:0] pc);
      op <= o; op_addr <= a;
      @(posedge clock);
      op <= PSI_OP_NONE;
      @(negedge clock);
      chk("fetch_addr", 32'(pc), 32'(fetch_addr));
      @(posedge clock);
   endtask : one
   initial
   begin
      repeat (3000) @(posedge clock);
      n_fail++;
      $display("[ERR] watchdog expected done seen hang");
      wrap_up();
   end
   initial
   begin
      do_reset();
      for (int i = 0; i <= 11; i++)
      begin
         op <= (i < 11) ? rows[i].o : PSI_OP_NONE;
         op_addr <= (i < 11) ? rows[i].a : 9'h000;
         op_lit <= (i < 11) ? rows[i].l : 8'h00;
         @(negedge clock);
         if (i > 0)
         begin
            chk("pc row", 32'(rows[i-1].pc), 32'(fetch_addr));
            chk("w row", 32'(rows[i-1].w), 32'(wreg_out));
         end
         @(posedge clock);
      end
      $display("row table done");
      apb(1'b0, PSI_ADDR_WREG, 32'h0);
      chk("wreg read", 32'h3c, q);
      apb(1'b1, PSI_ADDR_STATUS, 32'h20);
      apb(1'b0, PSI_ADDR_STATUS, 32'h0);
      chk("status", 32'h38, q);
      one(PSI_OP_JUMP, 9'h012, 12'h212);
      one(PSI_OP_CALL, 9'h134, 12'h234);
      apb(1'b1, PSI_ADDR_PCL, 32'h77);
      chk("pc low write", 32'h277, 32'(pc_seen));
      apb(1'b1, 8'h18, 32'hff);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("page tests done");
      apb(1'b1, PSI_ADDR_PTR, 32'h00);
      apb(1'b0, PSI_ADDR_PTR, 32'h0);
      chk("pointer ones", 32'hc0, q);
      apb(1'b1, PSI_ADDR_PTR, 32'h27);
      apb(1'b1, PSI_ADDR_DPORT, 32'ha5);
      @(negedge clock);
      chk("bank1 store", 32'ha5, 32'(u_psi_ram_model.mem[7'h27]));
      @(posedge clock);
      apb(1'b1, PSI_ADDR_PTR, 32'h07);
      apb(1'b1, PSI_ADDR_DPORT, 32'h5c);
      apb(1'b0, PSI_ADDR_DPORT, 32'h0);
      chk("indirect read", 32'h5c, q);
      apb(1'b1, PSI_ADDR_PTR, 32'h00);
      c = n_we;
      apb(1'b1, PSI_ADDR_DPORT, 32'h33);
      chk("self write", 32'(c), 32'(n_we));
      apb(1'b0, PSI_ADDR_DPORT, 32'h0);
      chk("self read", 32'h0, q);
      $display("indirect tests done");
      do_reset();
      apb(1'b0, PSI_ADDR_STATUS, 32'h0);
      chk("status reset", 32'h18, q);
      one(PSI_OP_JUMP, 9'h012, 12'h012);
      $display("second reset done");
      wrap_up();
   end
endmodule : psi_core_test

// ### psi_pkg.sv
// Package for program flow, return stack and indirect addressing block
// How it works
// - Counter holds next address, increments each cycle
// - Jump loads counter bits 8:0 from field
// - Status bit 5 supplies counter bit 9
// - Low counter register reads/writes counter 7:0
// - Call or low-counter write clears bit 8
// - Reset sets counter to all ones
// - After reset vector, counter wraps to 00h
// - Reset clears page select, page 0
// - Two-level 12-bit hidden return stack
// - Call shifts level 1 down, pushes counter+1
// - Deep calls keep only two newest
// - Return pops level 1, copies level 2 up
// - Deep returns keep giving level 2
// - Return loads working register with literal
// - No overflow or underflow flags exist
// - Data port access redirects through pointer
// - Indirect read of pointer zero gives 00h
// - Indirect write to pointer zero stores nothing
// - Pointer low five bits select address
// - No-bank variant: pointer 7:5 read ones
// - Two-bank variant: bit 5 banks, 7:6 ones
// - Four-bank variant: bits 6:5 bank, 7 one
// - Page bit set means page 1 200h-3FFh
package psi_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // -----------------------------------------------------------------
   localparam logic [7:0] PSI_ADDR_PTR    = 8'h00;
   localparam logic [7:0] PSI_ADDR_PCL    = 8'h04;
   localparam logic [7:0] PSI_ADDR_DPORT  = 8'h08;
   localparam logic [7:0] PSI_ADDR_STATUS = 8'h0c;
   localparam logic [7:0] PSI_ADDR_PC     = 8'h10;
   localparam logic [7:0] PSI_ADDR_WREG   = 8'h14;

   // -----------------------------------------------------------------
   // Fields and reset values
   // -----------------------------------------------------------------
   localparam int         PSI_PAGE_BIT    = 5;
   localparam int         PSI_PC_W        = 12;
   localparam logic [11:0] PSI_PC_RST     = 12'hfff;
   localparam logic [7:0] PSI_STATUS_RST  = 8'h18;
   localparam logic [7:0] PSI_PTR_RST     = 8'h00;
   localparam logic [7:0] PSI_DPORT_IDX   = 8'h00;

   // Bank count selects the variant: 1, 2 or 4
   localparam int         PSI_BANKS_DEF   = 2;

   typedef enum logic [2:0]
   {
      PSI_OP_NONE  = 3'b000,
      PSI_OP_JUMP  = 3'b001,
      PSI_OP_CALL  = 3'b010,
      PSI_OP_RET   = 3'b011,
      PSI_OP_PCLWR = 3'b100
   } psi_op_t;

   typedef struct packed
   {
      logic [11:0] pc;
      logic [11:0] stk1;
      logic [11:0] stk2;
      logic [7:0]  status;
      logic [7:0]  ptr;
      logic [7:0]  wreg;
      logic        pready;
      logic [31:0] prdata;
      logic [6:0]  ram_addr;
      logic        ram_we;
      logic        ram_re;
      logic [7:0]  ram_wdata;
   } psi_state_t;

endpackage : psi_pkg

// ### psi_ram_model.sv
// Data register file model behind the indirect port
`timescale 1ns/100ps
module psi_ram_model
(
   input  wire logic       clock,
   input  wire logic [6:0] ram_addr,
   input  wire logic       ram_we,
   input  wire logic       ram_re,
   input  wire logic [7:0] ram_wdata,
   output logic      [7:0] ram_rdata
);
   logic [7:0] mem [128];
   // Data stands only while the read strobe does; the inverse otherwise,
   // so a sample taken at the wrong edge shows up as a mismatch
   always @(posedge clock)
   begin
      if (ram_we)
         mem[ram_addr] <= ram_wdata;
   end
   assign ram_rdata = ram_re ? mem[ram_addr] : ~mem[ram_addr];
endmodule : psi_ram_model
